// >>> hdl/fsf_defs.svh
// Constants for the flywheel sensor filter and diagnosis block.
`ifndef FSF_DEFS_SVH
`define FSF_DEFS_SVH
`define FSF_CLK_MHZ 50
`define FSF_TMAX_US 200
`define FSF_TFIX_US 4
`define FSF_DIAG_MS 5
`define FSF_TMAX_CYC (`FSF_TMAX_US * `FSF_CLK_MHZ)
`define FSF_TFIX_CYC (`FSF_TFIX_US * `FSF_CLK_MHZ)
`define FSF_DIAG_CYC (`FSF_DIAG_MS * 1000 * `FSF_CLK_MHZ)
`define FSF_DIV_SHIFT 5
`define FSF_ADDR_CFG1 4'h1
`define FSF_ADDR_CFG5 4'h5
`define FSF_ADDR_CFG7 4'h7
`define FSF_ADDR_CTRL 4'h8
`define FSF_ADDR_STAT 4'h9
`define FSF_ADDR_IRQST 4'hA
`define FSF_ADDR_IRQEN 4'hB
`define FSF_ADDR_IRQCLR 4'hC
`define FSF_CFG1_LIMITED 0
`define FSF_CFG1_OPT_LO 1
`define FSF_CFG1_OPT_HI 2
`define FSF_CFG1_ENABLE 3
`define FSF_CFG5_HYST_LO 0
`define FSF_CFG5_HYST_HI 2
`define FSF_CFG5_FORCE 5
`define FSF_CFG7_FIXED 4
`define FSF_CTRL_DIAG 0
`define FSF_HYST_LOWEST 3'h0
`define FSF_HYST_MAX 3'h4
`define FSF_IRQ_DONE 0
`define FSF_IRQ_EDGE 1
`define FSF_IRQ_REFUSED 2
`endif

// >>> hdl/fsf_pkg.sv
// Types shared by the flywheel sensor filter and diagnosis block.
`default_nettype none
package fsf_pkg;
   typedef struct packed
   {
      logic [3:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } fsf_bus_t;
   typedef struct packed
   {
      logic sensor_absent;
      logic short_gnd;
      logic short_bat;
   } fsf_probe_t;
   typedef enum logic [1:0]
   {
      FSF_IDLE,
      FSF_RUN,
      FSF_DONE
   } fsf_diag_state_t;
endpackage
`default_nettype wire

// >>> hdl/fsf_edge_filter.sv
// Edge filter: rising edges qualified by a hold time, falling edges passed then masked.
`default_nettype none
`include "fsf_defs.svh"
module fsf_edge_filter
   import fsf_pkg::*;
#(
   parameter int CW = 18
)
(
   input wire logic clock,
   input wire logic rst,
   input wire logic in_sq,
   input wire logic [CW-1:0] tfilt,
   input wire logic rise_filter,
   input wire logic fall_mask,
   input wire logic hold_low,
   output logic out_q,
   output logic rise_evt
);
   typedef struct packed
   {
      logic out;
      logic evt;
      logic [CW-1:0] cnt;
      logic masking;
   } fsf_ef_state_t;
   fsf_ef_state_t s, next_s;

   // Next state: a rising input must persist tfilt cycles; a fall passes at once.
   always_comb
   begin
      next_s = s;
      next_s.evt = 1'b0;
      if (hold_low)
      begin
         next_s = '0;
      end
      else if (s.masking)
      begin
         if (s.cnt >= tfilt)
         begin
            next_s.masking = 1'b0;
            next_s.cnt = '0;
         end
         else
         begin
            next_s.cnt = s.cnt + 1'b1;
         end
      end
      else if (!s.out)
      begin
         if (!in_sq)
         begin
            next_s.cnt = '0;
         end
         else if (!rise_filter || s.cnt >= tfilt)
         begin
            next_s.out = 1'b1;
            next_s.evt = 1'b1;
            next_s.cnt = '0;
         end
         else
         begin
            next_s.cnt = s.cnt + 1'b1;
         end
      end
      else if (!in_sq)
      begin
         next_s.out = 1'b0;
         next_s.masking = fall_mask;
         next_s.cnt = '0;
      end
   end

   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
         s <= '0;
      else
         s <= next_s;
   end

   assign out_q = s.out;
   assign rise_evt = s.evt;

   // A fall of the output follows a fall of the input within one cycle.
   fall_pass_a: assert property (@(posedge clock) disable iff (rst)
      (s.out && !s.masking && !in_sq && !hold_low) |=> !out_q)
      else $error("Falling edge was not passed at once.");
endmodule
`default_nettype wire

// >>> hdl/fsf_diag_seq.sv
// Sensor diagnosis sequencer with a minimum run time.
`default_nettype none
`include "fsf_defs.svh"
module fsf_diag_seq
   import fsf_pkg::*;
#(
   parameter int DIAG_CYC = `FSF_DIAG_CYC
)
(
   input wire logic clock,
   input wire logic rst,
   input wire logic start,
   input wire fsf_pkg::fsf_probe_t probe,
   output logic busy,
   output logic done,
   output logic result,
   output logic status
);
   typedef struct packed
   {
      fsf_diag_state_t st;
      logic [23:0] cnt;
      logic res;
      logic sts;
      logic dn;
   } fsf_dg_state_t;
   fsf_dg_state_t s, next_s;

   // Sequencer: run the probes for the full time, then store the outcome last.
   always_comb
   begin
      next_s = s;
      next_s.dn = 1'b0;
      case (s.st)
         FSF_IDLE:
         begin
            if (start)
            begin
               next_s.st = FSF_RUN;
               next_s.cnt = '0;
            end
         end
         FSF_RUN:
         begin
            if (s.cnt >= 24'(DIAG_CYC - 1))
               next_s.st = FSF_DONE;
            else
               next_s.cnt = s.cnt + 24'h000001;
         end
         FSF_DONE:
         begin
            // Result is the fault verdict; status says the sensor is usable.
            next_s.res = probe.sensor_absent | probe.short_gnd | probe.short_bat;
            next_s.sts = ~(probe.sensor_absent | probe.short_gnd | probe.short_bat);
            next_s.dn = 1'b1;
            next_s.st = FSF_IDLE;
         end
         default:
            next_s.st = FSF_IDLE;
      endcase
   end

   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
         s <= '0;
      else
         s <= next_s;
   end

   assign busy = (s.st != FSF_IDLE);
   assign done = s.dn;
   assign result = s.res;
   assign status = s.sts;

   sequence diag_start_s;
      (s.st == FSF_IDLE) && start;
   endsequence
   // The run stays busy for at least eight cycles after its start.
   diag_min_time_a: assert property (@(posedge clock) disable iff (rst)
      diag_start_s |=> busy [*8])
      else $error("Diagnosis ended too early.");
endmodule
`default_nettype wire

// >>> hdl/fsf_top.sv
// Flywheel sensor filter, hysteresis control and diagnosis, top level.
//
// Contract
// - Option code picks hysteresis feedback source.
// - Codes 10/11 filter rises, mask falls.
// - Fixed-filter bit gives 4 us filter.
// - Limited mode holds filter at 4 us.
// - Limited mode keeps hysteresis at or above minimum unless forced.
// - Force bit drives hysteresis to lowest.
// - No diagnosis in limited mode.
// - Diagnosis checks presence and shorts.
// - Diagnosis suspends normal processing and output.
// - Diagnosis lasts at least 5 ms.
// - Last step stores result and status.
// - New request reruns and overwrites results.
// - Adaptive filter is period over 32.
// - Rise needs hold time; fall passes, masks.
// - Filter resets to 200 us maximum.
`default_nettype none
`include "fsf_defs.svh"
module fsf_top
   import fsf_pkg::*;
#(
   parameter int CW = 18,
   parameter int DIAG_CYC = `FSF_DIAG_CYC
)
(
   input wire logic clock,
   input wire logic rst,
   input wire logic [3:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   input wire logic sensor_sq,
   input wire fsf_pkg::fsf_probe_t probe,
   input wire logic [2:0] amp_hyst,
   output logic [2:0] hyst_level,
   output logic hyst_feedback,
   output logic sensor_out,
   output logic diag_mode,
   output logic irq
);
   import fsf_pkg::*;

   typedef struct packed
   {
      logic [2:0] sync;
      logic [7:0] cfg1;
      logic [7:0] cfg5;
      logic [7:0] cfg7;
      logic [2:0] irq_st;
      logic [2:0] irq_en;
      logic [7:0] rdata;
      logic [CW-1:0] per_cnt;
      logic [CW-1:0] tadapt;
      logic have_edge;
      logic out;
      logic [2:0] hyst;
      logic fb;
      logic was_busy;
      logic enable_d;
      logic clean;
      logic [23:0] diag_len;
   } fsf_top_state_t;
   fsf_top_state_t s, next_s;

   fsf_bus_t bus;
   logic filt_out;
   logic rise_evt;
   logic diag_busy;
   logic diag_done;
   logic diag_result;
   logic diag_status;
   logic diag_start;
   logic [CW-1:0] tfilt;
   logic [1:0] opt;
   logic limited;
   logic enable;
   logic restart;
   logic in_clean;
   logic probe_fault;

   // Clamp helper used for both adaptive limits.
   function automatic logic [CW-1:0] fsf_clamp(input logic [CW-1:0] v);
      if (v > CW'(`FSF_TMAX_CYC))
         fsf_clamp = CW'(`FSF_TMAX_CYC);
      else if (v < CW'(`FSF_TFIX_CYC))
         fsf_clamp = CW'(`FSF_TFIX_CYC);
      else
         fsf_clamp = v;
   endfunction

   assign bus = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};
   assign opt = s.cfg1[`FSF_CFG1_OPT_HI:`FSF_CFG1_OPT_LO];
   assign limited = s.cfg1[`FSF_CFG1_LIMITED];
   assign enable = s.cfg1[`FSF_CFG1_ENABLE];
   // Input counts only when the last two sync stages agree; else the last agreed level holds.
   assign in_clean = (s.sync[2] == s.sync[1]) ? s.sync[1] : s.clean;
   // Any probe comparator that trips makes the diagnosis a fault.
   assign probe_fault = probe.sensor_absent | probe.short_gnd | probe.short_bat;
   assign restart = (enable && !s.enable_d) || (s.was_busy && !diag_busy);
   // Fixed filter wins over the adaptive value in either configuration.
   assign tfilt = (limited || s.cfg7[`FSF_CFG7_FIXED]) ? CW'(`FSF_TFIX_CYC)
                  : s.tadapt;
   // A diagnosis request in limited mode is refused.
   assign diag_start = bus.wr && bus.addr == `FSF_ADDR_CTRL
                       && bus.wdata[`FSF_CTRL_DIAG] && !limited && !diag_busy;

   fsf_edge_filter #(.CW(CW)) u_filter (
      .clock(clock),
      .rst(rst),
      .in_sq(in_clean),
      .tfilt(tfilt),
      .rise_filter(opt[1]),
      .fall_mask(opt[1]),
      .hold_low(diag_busy || !enable),
      .out_q(filt_out),
      .rise_evt(rise_evt)
   );

   fsf_diag_seq #(.DIAG_CYC(DIAG_CYC)) u_diag (
      .clock(clock),
      .rst(rst),
      .start(diag_start),
      .probe(probe),
      .busy(diag_busy),
      .done(diag_done),
      .result(diag_result),
      .status(diag_status)
   );

   // Main next-state logic: registers, period measurement, hysteresis, events.
   always_comb
   begin
      next_s = s;
      next_s.sync = {s.sync[1:0], sensor_sq};
      // Remember the last level on which the last two stages agreed.
      next_s.clean = in_clean;
      // Length of the running diagnosis, watched by the minimum-time check.
      next_s.diag_len = diag_busy ? s.diag_len + 24'h000001 : 24'h000000;
      next_s.was_busy = diag_busy;
      next_s.enable_d = enable;
      next_s.rdata = 8'h00;
      // Register writes.
      if (bus.wr)
      begin
         case (bus.addr)
            `FSF_ADDR_CFG1: next_s.cfg1 = bus.wdata;
            `FSF_ADDR_CFG5: next_s.cfg5 = bus.wdata;
            `FSF_ADDR_CFG7: next_s.cfg7 = bus.wdata;
            `FSF_ADDR_IRQEN: next_s.irq_en = bus.wdata[2:0];
            `FSF_ADDR_IRQCLR: next_s.irq_st = s.irq_st & ~bus.wdata[2:0];
            default: next_s.rdata = 8'h00;
         endcase
      end
      // Register reads, answered in the next cycle; unmapped reads return zero.
      if (bus.rd)
      begin
         case (bus.addr)
            `FSF_ADDR_CFG1: next_s.rdata = s.cfg1;
            `FSF_ADDR_CFG5: next_s.rdata = s.cfg5;
            `FSF_ADDR_CFG7: next_s.rdata = s.cfg7;
            `FSF_ADDR_STAT: next_s.rdata = {4'h0, s.out, diag_busy, diag_status, diag_result};
            `FSF_ADDR_IRQST: next_s.rdata = {5'h00, s.irq_st};
            `FSF_ADDR_IRQEN: next_s.rdata = {5'h00, s.irq_en};
            default: next_s.rdata = 8'h00;
         endcase
      end
      // Period measurement between qualified rises; restart drops back to maximum.
      if (restart)
      begin
         next_s.tadapt = CW'(`FSF_TMAX_CYC);
         next_s.per_cnt = '0;
         next_s.have_edge = 1'b0;
      end
      else if (rise_evt)
      begin
         if (s.have_edge && !limited)
            next_s.tadapt = fsf_clamp(s.per_cnt >> `FSF_DIV_SHIFT);
         next_s.per_cnt = '0;
         next_s.have_edge = 1'b1;
      end
      else if (s.per_cnt != {CW{1'b1}})
      begin
         next_s.per_cnt = s.per_cnt + 1'b1;
      end
      // Output is frozen low while diagnosing.
      next_s.out = filt_out && !diag_busy;
      // Feedback source: comparator for 00/10, filtered output for 01/11.
      next_s.fb = opt[0] ? filt_out : in_clean;
      // Hysteresis: force wins; limited mode floors at the programmed minimum.
      if (s.cfg5[`FSF_CFG5_FORCE])
         next_s.hyst = `FSF_HYST_LOWEST;
      else if (limited && amp_hyst < s.cfg5[`FSF_CFG5_HYST_HI:`FSF_CFG5_HYST_LO])
         next_s.hyst = s.cfg5[`FSF_CFG5_HYST_HI:`FSF_CFG5_HYST_LO];
      else
         next_s.hyst = amp_hyst;
      // Sticky events; a new event wins over a clear in the same cycle.
      if (diag_done)
         next_s.irq_st[`FSF_IRQ_DONE] = 1'b1;
      if (rise_evt)
         next_s.irq_st[`FSF_IRQ_EDGE] = 1'b1;
      if (bus.wr && bus.addr == `FSF_ADDR_CTRL && bus.wdata[`FSF_CTRL_DIAG] && limited)
         next_s.irq_st[`FSF_IRQ_REFUSED] = 1'b1;
   end

   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         s <= '0;
         s.tadapt <= CW'(`FSF_TMAX_CYC);
      end
      else
      begin
         s <= next_s;
      end
   end

   assign reg_rdata = s.rdata;
   assign sensor_out = s.out;
   assign hyst_level = s.hyst;
   assign hyst_feedback = s.fb;
   assign diag_mode = diag_busy;
   assign irq = |(s.irq_st & s.irq_en);

   // Output stays low from the second cycle of a diagnosis on.
   diag_quiet_a: assert property (@(posedge clock) disable iff (rst)
      $past(diag_busy) && diag_busy |-> !sensor_out)
      else $error("Output moved during diagnosis.");
   // Force bit yields lowest hysteresis next cycle.
   force_hyst_a: assert property (@(posedge clock) disable iff (rst)
      s.cfg5[`FSF_CFG5_FORCE] |=> hyst_level == `FSF_HYST_LOWEST)
      else $error("Forced hysteresis not lowest.");
   // Limited mode never drops under the minimum unless forced.
   hyst_floor_a: assert property (@(posedge clock) disable iff (rst)
      limited && !s.cfg5[`FSF_CFG5_FORCE] && $stable(s.cfg5) ##1 limited
      |-> hyst_level >= $past(s.cfg5[`FSF_CFG5_HYST_HI:`FSF_CFG5_HYST_LO]))
      else $error("Hysteresis below minimum.");
   // No diagnosis starts in limited mode.
   diag_refuse_a: assert property (@(posedge clock) disable iff (rst)
      limited && !diag_busy |=> !diag_busy)
      else $error("Diagnosis started in limited mode.");
   // Fixed filter selects the fixed count.
   fixed_filt_a: assert property (@(posedge clock) disable iff (rst)
      (limited || s.cfg7[`FSF_CFG7_FIXED]) |-> tfilt == CW'(`FSF_TFIX_CYC))
      else $error("Fixed filter not applied.");
   // Restart loads the maximum filter time.
   filt_reset_a: assert property (@(posedge clock) disable iff (rst)
      restart |=> s.tadapt == CW'(`FSF_TMAX_CYC))
      else $error("Filter time not reset to maximum.");
   // Feedback follows the filtered output when option bit zero is set.
   feedback_a: assert property (@(posedge clock) disable iff (rst)
      opt[0] |=> hyst_feedback == $past(filt_out))
      else $error("Feedback source wrong.");
   // Completion raises a sticky done event.
   done_flag_a: assert property (@(posedge clock) disable iff (rst)
      diag_done |=> s.irq_st[`FSF_IRQ_DONE])
      else $error("Done event lost.");
   // Every finished diagnosis must have run for the full minimum time.
   diag_len_a: assert property (@(posedge clock) disable iff (rst)
      $fell(diag_busy) |-> s.diag_len >= 24'(DIAG_CYC))
      else $error("Diagnosis shorter than its minimum time.");
   // A qualified rise after a measured period loads period over 32.
   adapt_div_a: assert property (@(posedge clock) disable iff (rst)
      rise_evt && s.have_edge && !limited && !restart
      |=> s.tadapt == fsf_clamp($past(s.per_cnt) >> `FSF_DIV_SHIFT))
      else $error("Adaptive filter not period over 32.");
   // Each qualified rise starts a new period count.
   period_start_a: assert property (@(posedge clock) disable iff (rst)
      rise_evt && !restart |=> s.per_cnt == '0 && s.have_edge)
      else $error("Period count not restarted on a rise.");
   // A restart forgets the partial period as well as the filter time.
   period_drop_a: assert property (@(posedge clock) disable iff (rst)
      restart |=> s.per_cnt == '0 && !s.have_edge)
      else $error("Period measurement not restarted.");
   // The stored outcome is the probe verdict from the final step.
   diag_store_a: assert property (@(posedge clock) disable iff (rst)
      diag_done |-> diag_result == $past(probe_fault) && diag_status == !$past(probe_fault))
      else $error("Diagnosis outcome not stored.");
   // Feedback comes from the comparator side when option bit zero is clear.
   feedback_comp_a: assert property (@(posedge clock) disable iff (rst)
      !opt[0] |=> hyst_feedback == $past(in_clean))
      else $error("Comparator feedback source wrong.");
   // A refused request leaves its sticky flag set.
   refuse_flag_a: assert property (@(posedge clock) disable iff (rst)
      bus.wr && bus.addr == `FSF_ADDR_CTRL && bus.wdata[`FSF_CTRL_DIAG] && limited
      |=> s.irq_st[`FSF_IRQ_REFUSED])
      else $error("Refused request not flagged.");
   // Read data are zero except in the cycle after a read strobe.
   read_idle_a: assert property (@(posedge clock) disable iff (rst)
      !$past(reg_rd) |-> reg_rdata == 8'h00)
      else $error("Read data outside the read answer cycle.");
   // A disagreeing pair of sync stages never moves the accepted level.
   sync_hold_a: assert property (@(posedge clock) disable iff (rst)
      s.sync[2] != s.sync[1] |=> s.clean == $past(s.clean))
      else $error("Unsettled input was accepted.");
endmodule
`default_nettype wire

// >>> verif/fsf_sensor_model.sv
// Behavioural sensor front end: squared comparator signal and diagnosis comparators.
`default_nettype none
module fsf_sensor_model
   import fsf_pkg::*;
(
   input wire logic clock,
   input wire logic lvl,
   input wire fsf_pkg::fsf_probe_t fault,
   output logic sensor_sq,
   output var fsf_pkg::fsf_probe_t probe
);
   timeunit 1ns;
   timeprecision 1ns;
   import fsf_pkg::*;
   // Start quiet so the block never sees an unknown comparator level.
   initial
   begin
      sensor_sq = 1'b0;
      probe = 3'h0;
   end
   // The comparators settle a cycle after the sensor moves, like a real front end.
   always @(posedge clock)
   begin
      sensor_sq <= lvl;
      probe <= fault;
   end
endmodule
`default_nettype wire

// >>> verif/tb.sv
// Self-checking bench for the flywheel sensor filter and diagnosis block.
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   import fsf_pkg::*;
   localparam int DC = 20;
   logic clock = 1'b0;
   logic rst = 1'b1;
   logic [3:0] reg_addr = 4'h0;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [7:0] reg_rdata;
   logic sensor_sq;
   fsf_probe_t probe;
   logic [2:0] amp_hyst = 3'h0;
   logic [2:0] hyst_level;
   logic hyst_feedback;
   logic sensor_out;
   logic diag_mode;
   logic irq;
   logic lvl = 1'b0;
   fsf_probe_t fault = 3'h0;
   logic [7:0] d;
   int err_count = 0;
   int checks = 0;
   // The short diagnosis time keeps the run brief; the diagnosis waits derive from DC.
   fsf_top #(.CW(18), .DIAG_CYC(DC)) DUT (.clock(clock), .rst(rst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .sensor_sq(sensor_sq), .probe(probe), .amp_hyst(amp_hyst), .hyst_level(hyst_level),
      .hyst_feedback(hyst_feedback), .sensor_out(sensor_out), .diag_mode(diag_mode), .irq(irq));
   fsf_sensor_model model (.clock(clock), .lvl(lvl), .fault(fault), .sensor_sq(sensor_sq),
      .probe(probe));
   // Free-running 50 MHz clock.
   initial
   begin
      forever #10 clock = ~clock;
   end
   task automatic tally_and_finish();
      $display("checks %0d err_count %0d", checks, err_count);
      if (err_count == 0 && checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   // Shared comparison; case inequality so an unknown never passes.
   task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
      checks++;
      if (s !== e)
      begin
         err_count++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, s);
      end
   endtask
   // Steps one nanosecond past the edge so that edge's updates have landed.
   task automatic wt(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] v);
      @(posedge clock);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge clock);
      reg_wr <= 1'b0;
      #1;
   endtask
   // Read data stand only in the cycle after the strobe, so they are taken there.
   task automatic rd(input logic [3:0] a);
      @(posedge clock);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clock);
      reg_rd <= 1'b0;
      #1;
      d = reg_rdata;
   endtask
   task automatic setl(input logic v);
      @(posedge clock);
      lvl <= v;
   endtask
   task automatic t_regs();
      logic [3:0] a [7] = '{4'h1, 4'h5, 4'h7, 4'h9, 4'hA, 4'hB, 4'hD};
      wr(4'hD, 8'hFF);
      foreach (a[i])
      begin
         rd(a[i]);
         chk("reset value", d, 8'h00);
      end
      chk("irq idle", irq, 1'b0);
   endtask
   // A short pulse under each option code; the filter, down at its 4 us minimum after the first two unfiltered rises, holds filtered rises.
   task automatic t_fb();
      logic [1:0] c;
      logic eo;
      for (int i = 0; i < 4; i++)
      begin
         c = 2'(i);
         wr(4'h1, {5'h01, c, 1'b0});
         setl(1'b1);
         wt(12);
         eo = ~c[1];
         chk("filtered output", sensor_out, eo);
         chk("feedback", hyst_feedback, c[0] ? eo : 1'b1);
         setl(1'b0);
         wt(12);
      end
   endtask
   task automatic t_adapt();
      wr(4'h1, 8'h00);
      wr(4'h1, 8'h0C);
      setl(1'b1);
      wt(9000);
      chk("out before max filter", sensor_out, 1'b0);
      wt(1200);
      chk("out after max filter", sensor_out, 1'b1);
      setl(1'b0);
      wt(8);
      chk("fall passed", sensor_out, 1'b0);
      wt(10500);
      // Unfiltered rises 12802 cycles apart give a filter of 400 cycles.
      wr(4'h1, 8'h08);
      repeat (2)
      begin
         setl(1'b1);
         wt(6400);
         setl(1'b0);
         wt(6400);
      end
      wr(4'h1, 8'h0C);
      setl(1'b1);
      wt(350);
      chk("inside period filter", sensor_out, 1'b0);
      wt(100);
      chk("after period filter", sensor_out, 1'b1);
      setl(1'b0);
      wt(500);
   endtask
   task automatic fixp();
      setl(1'b1);
      wt(150);
      chk("inside fixed filter", sensor_out, 1'b0);
      wt(100);
      chk("after fixed filter", sensor_out, 1'b1);
      setl(1'b0);
      wt(300);
   endtask
   task automatic t_diag();
      wr(4'h1, 8'h08);
      wr(4'hB, 8'h05);
      fault <= 3'b010;
      setl(1'b1);
      wt(12);
      chk("out before diag", sensor_out, 1'b1);
      wr(4'h8, 8'h01);
      wt(2);
      chk("out held in diag", sensor_out, 1'b0);
      chk("diag mode", diag_mode, 1'b1);
      wt(DC - 4);
      chk("still running", diag_mode, 1'b1);
      wt(8);
      chk("diag over", diag_mode, 1'b0);
      chk("done irq", irq, 1'b1);
      rd(4'h9);
      chk("diag result", d & 8'h07, 8'h01);
      wr(4'hC, 8'h01);
      wt(1);
      chk("irq cleared", irq, 1'b0);
      fault <= 3'b000;
      wr(4'h8, 8'h01);
      setl(1'b0);
      wt(DC + 6);
      rd(4'h9);
      chk("rerun result", d & 8'h07, 8'h02);
      wr(4'h1, 8'h0C);
      setl(1'b1);
      wt(500);
      chk("filter restarted", sensor_out, 1'b0);
      setl(1'b0);
      wt(20);
      wr(4'h7, 8'h10);
      fixp();
      wr(4'h7, 8'h00);
   endtask
   // Limited mode: hysteresis floor and force, refused diagnosis, fixed filter.
   task automatic t_lim();
      wr(4'h1, 8'h0D);
      wr(4'h5, 8'h03);
      wt(4);
      chk("hysteresis floor", hyst_level, 3'h3);
      @(posedge clock);
      amp_hyst <= 3'h4;
      wt(4);
      chk("amplitude above floor", hyst_level, 3'h4);
      wr(4'h5, 8'h23);
      wt(3);
      chk("forced lowest", hyst_level, 3'h0);
      wr(4'h5, 8'h03);
      wt(3);
      chk("force released", hyst_level, 3'h4);
      // Clear every earlier event so only the refusal can raise the interrupt.
      wr(4'hC, 8'h07);
      wr(4'h8, 8'h01);
      wt(2);
      chk("diag refused", diag_mode, 1'b0);
      rd(4'hA);
      chk("refused flag", d, 8'h04);
      chk("refused irq", irq, 1'b1);
      wr(4'hB, 8'h00);
      wt(1);
      chk("irq masked", irq, 1'b0);
      fixp();
   endtask
   // Hang guard: the whole sequence needs about 49000 cycles.
   initial
   begin
      #(80000 * 20);
      err_count++;
      tally_and_finish();
   end
   initial
   begin
      repeat (5) @(posedge clock);
      rst <= 1'b0;
      t_regs();
      t_fb();
      t_adapt();
      t_diag();
      t_lim();
      tally_and_finish();
   end
endmodule
`default_nettype wire
